/* src/bxp_ports.sv */
// Summary of operation
// RL1: configuration eeprom sits at 0x50; this block leaves that address alone.
// RL2: memory presence-detect eeprom sits at 0x51; left unanswered here.
// RL3: output expander answers 0x38 only and holds an eight-bit output port.
// RL4: port bits 0 and 1 drive indicators, lit at 0; they read back 1.
// RL5: port bit 2 drives phy power-down; 0 powers down, 1 runs.
// RL6: input expander answers 0x39 only and returns an eight-bit status byte.
// RL7: two input bits give board revision: 00, 01, 10, 11 reserved.
// RL8: revision, reserved, capability and boot bits ignore master writes.
// RL9: input bit 5 mirrors the slot 66 MHz capability line.
// RL10: input bit 6 reports boot flash selection, 1 meaning second bank.
// RL11: real-time clock sits at 0x68; left unanswered here.
// RL12: ack own address, latch written byte, read byte sampled at phase start.
`timescale 1ns/100ps
`default_nettype none

module bxp_ports
    import bxp_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // second management bus
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe_n,
    // output expander lines
    output logic      green_indicator_ctl,
    output logic      yellow_indicator_ctl,
    output logic      phy_power_down_ctl,
    output logic      display_enable_reserved,
    // input expander lines
    input  wire logic board_revision_hi,
    input  wire logic board_revision_lo,
    input  wire logic mini_slot_clock_run,
    input  wire logic slot_66mhz_capable,
    input  wire logic boot_second_bank
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic is_out_exp(input logic [6:0] a);
        return a == OUT_EXP_ADDR;
    endfunction : is_out_exp

    function automatic logic is_in_exp(input logic [6:0] a);
        return a == IN_EXP_ADDR;
    endfunction : is_in_exp

    // ------------------------------------------------------------
    // bus line conditioning
    // ------------------------------------------------------------
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    bxp_line_cond u_line (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .scl_pin   (scl_in),
        .sda_pin   (sda_in),
        .scl_s     (scl_s),
        .sda_s     (sda_s),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .start_det (start_det),
        .stop_det  (stop_det)
    );

    // ------------------------------------------------------------
    // status pin synchroniser
    // ------------------------------------------------------------
    logic [4:0] stat_meta_reg;
    logic [4:0] stat_reg;
    logic [4:0] stat_pins;

    assign stat_pins = {boot_second_bank, slot_66mhz_capable,
                        mini_slot_clock_run, board_revision_hi,
                        board_revision_lo};

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_stat_sync
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    stat_meta_reg[gi] <= 1'b1;
                    stat_reg[gi]      <= 1'b1;
                end else begin
                    stat_meta_reg[gi] <= stat_pins[gi];
                    stat_reg[gi]      <= stat_meta_reg[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // transfer engine state
    // ------------------------------------------------------------
    bxp_state_t state_reg;
    bxp_state_t state_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic       rw_reg;
    logic       rw_next;
    logic       sel_in_reg;
    logic       sel_in_next;
    logic [7:0] out_port_reg;
    logic [7:0] out_port_next;
    logic       clkrun_reg;
    logic       clkrun_next;
    logic       sda_oe_n_reg;
    logic       sda_oe_n_next;
    logic       drive;
    logic       addr_done;
    logic       wr_strobe;
    logic       rd_load;
    logic [7:0] in_byte;

    assign addr_done = scl_fall && state_reg == ST_ADDR
                       && cnt_reg == BIT_COUNT;
    assign wr_strobe = scl_fall && state_reg == ST_WR_DATA
                       && cnt_reg == BIT_COUNT;
    assign rd_load   = scl_fall && ((state_reg == ST_ADDR_ACK && rw_reg)
                       || (state_reg == ST_RD_ACK && !rw_reg));

    // status byte built from synchronised pins
    always_comb begin
        in_byte             = IN_IDLE;
        in_byte[REV_LO_BIT] = stat_reg[0];                        // RL7
        in_byte[REV_HI_BIT] = stat_reg[1];                        // RL7
        in_byte[CLKRUN_BIT] = stat_reg[2] & clkrun_reg;
        in_byte[M66_BIT]    = stat_reg[3];                        // RL9
        in_byte[BOOT_BIT]   = stat_reg[4];                        // RL10
    end

    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        shift_next    = shift_reg;
        rw_next       = rw_reg;
        sel_in_next   = sel_in_reg;
        out_port_next = out_port_reg;
        clkrun_next   = clkrun_reg;
        unique case (state_reg)
            ST_IDLE: ;
            ST_ADDR: begin
                if (scl_rise && cnt_reg != BIT_COUNT) begin
                    shift_next = {shift_reg[6:0], sda_s};
                    cnt_next   = cnt_reg + 4'h1;
                end
                if (addr_done) begin
                    rw_next     = shift_reg[0];
                    sel_in_next = is_in_exp(shift_reg[7:1]);
                    if (is_out_exp(shift_reg[7:1])
                        || is_in_exp(shift_reg[7:1]))             // RL3 RL6
                        state_next = ST_ADDR_ACK;                 // RL12
                    else
                        state_next = ST_IDLE;                     // RL1 RL2 RL11
                end
            end
            ST_ADDR_ACK: begin
                if (scl_fall) begin
                    cnt_next = CNT_RST;
                    if (rw_reg) begin
                        shift_next = sel_in_reg ? in_byte
                                                : OUT_READBACK;   // RL4 RL12
                        state_next = ST_RD_DATA;
                    end else begin
                        state_next = ST_WR_DATA;
                    end
                end
            end
            ST_WR_DATA: begin
                if (scl_rise && cnt_reg != BIT_COUNT) begin
                    shift_next = {shift_reg[6:0], sda_s};
                    cnt_next   = cnt_reg + 4'h1;
                end
                if (wr_strobe) begin
                    state_next = ST_WR_ACK;
                    if (sel_in_reg)
                        clkrun_next = shift_reg[CLKRUN_BIT];      // RL8
                    else
                        out_port_next = shift_reg;                // RL3 RL12
                end
            end
            ST_WR_ACK: begin
                if (scl_fall) begin
                    cnt_next   = CNT_RST;
                    state_next = ST_WR_DATA;
                end
            end
            ST_RD_DATA: begin
                if (scl_fall) begin
                    shift_next = {shift_reg[6:0], 1'b1};
                    cnt_next   = cnt_reg + 4'h1;
                    if (cnt_reg == BIT_LAST)
                        state_next = ST_RD_ACK;
                end
            end
            ST_RD_ACK: begin
                if (scl_rise)
                    rw_next = sda_s;
                if (scl_fall) begin
                    cnt_next = CNT_RST;
                    if (!rw_reg) begin
                        // master acked: fresh sample for next byte
                        shift_next = sel_in_reg ? in_byte
                                                : OUT_READBACK;   // RL12
                        rw_next    = 1'b1;
                        state_next = ST_RD_DATA;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
        endcase
        if (start_det) begin
            state_next = ST_ADDR;
            cnt_next   = CNT_RST;
        end else if (stop_det) begin
            state_next = ST_IDLE;
        end
    end

    // data line drive, open drain: oe_n low pulls the line down
    always_comb begin
        drive = (state_next == ST_ADDR_ACK) || (state_next == ST_WR_ACK)
                || (state_next == ST_RD_DATA && !shift_next[7]);  // RL12
        sda_oe_n_next = !drive;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg    <= ST_IDLE;
            cnt_reg      <= CNT_RST;
            shift_reg    <= BYTE_RST;
            rw_reg       <= 1'b0;
            sel_in_reg   <= 1'b0;
            out_port_reg <= OUT_PORT_RST;
            clkrun_reg   <= CLKRUN_RST;
            sda_oe_n_reg <= 1'b1;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            shift_reg    <= shift_next;
            rw_reg       <= rw_next;
            sel_in_reg   <= sel_in_next;
            out_port_reg <= out_port_next;
            clkrun_reg   <= clkrun_next;
            sda_oe_n_reg <= sda_oe_n_next;
        end
    end

    // ------------------------------------------------------------
    // output flops
    // ------------------------------------------------------------
    logic [3:0] pin_reg;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pin_reg <= 4'hF;
        end else begin
            pin_reg <= {out_port_reg[DISP_EN_BIT],
                        out_port_reg[PHY_PD_BIT],                 // RL5
                        out_port_reg[YELLOW_BIT],                 // RL4
                        out_port_reg[GREEN_BIT]};                 // RL4
        end
    end

    assign green_indicator_ctl     = pin_reg[0];
    assign yellow_indicator_ctl    = pin_reg[1];
    assign phy_power_down_ctl      = pin_reg[2];
    assign display_enable_reserved = pin_reg[3];
    assign sda_oe_n                = sda_oe_n_reg;

    logic sda_out_reg;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst)
            sda_out_reg <= 1'b0;
        else
            sda_out_reg <= 1'b0;
    end

    assign sda_out = sda_out_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_out_addr_ack: assert property (                             // RL3
        addr_done && shift_reg[7:1] == 7'h38 |=> state_reg == ST_ADDR_ACK)
        else $error("output expander address not acknowledged");
    a_in_addr_ack: assert property (                              // RL6
        addr_done && shift_reg[7:1] == 7'h39 |=> state_reg == ST_ADDR_ACK
        && sel_in_reg)
        else $error("input expander address not acknowledged");
    a_foreign_addr_nak: assert property (                         // RL1
        addr_done && (shift_reg[7:1] == 7'h50 || shift_reg[7:1] == 7'h51
        || shift_reg[7:1] == 7'h68) |=> state_reg == ST_IDLE)
        else $error("foreign target address was claimed");
    a_led_write: assert property (                                // RL4
        wr_strobe && !sel_in_reg |=> ##1
        green_indicator_ctl == $past(shift_reg[0], 2)
        && yellow_indicator_ctl == $past(shift_reg[1], 2))
        else $error("indicator lines do not follow written byte");
    a_phy_write: assert property (                                // RL5
        wr_strobe && !sel_in_reg |=> ##1
        phy_power_down_ctl == $past(shift_reg[2], 2))
        else $error("phy power-down line does not follow write");
    a_out_readback: assert property (                             // RL4
        rd_load && !sel_in_reg |=> shift_reg == 8'hFF)
        else $error("output expander read not all ones");
    a_rev_code: assert property (                                 // RL7
        rd_load && sel_in_reg |=> shift_reg[1:0] == $past(stat_reg[1:0]))
        else $error("revision code not returned");
    a_ro_write: assert property (                                 // RL8
        wr_strobe && sel_in_reg |=> out_port_reg == $past(out_port_reg)
        && in_byte[3:0] == $past(in_byte[3:0]) || $changed(stat_reg))
        else $error("write to input expander disturbed state");
    a_m66_mirror: assert property (                               // RL9
        rd_load && sel_in_reg |=> shift_reg[5] == $past(stat_reg[3]))
        else $error("66 MHz capability bit not mirrored");
    a_boot_bit: assert property (                                 // RL10
        rd_load && sel_in_reg |=> shift_reg[6] == $past(stat_reg[4]))
        else $error("boot selection bit not reported");
    a_ack_drive: assert property (                                // RL12
        state_reg == ST_ADDR_ACK && $past(state_reg) == ST_ADDR_ACK
        |-> !sda_oe_n_reg)
        else $error("address acknowledge not driven");

    c_out_write: cover property (wr_strobe && !sel_in_reg);
    c_in_read: cover property (rd_load && sel_in_reg);
    c_foreign: cover property (addr_done ##1 state_reg == ST_IDLE);
    c_multi_read: cover property (
        state_reg == ST_RD_ACK ##1 state_reg == ST_RD_DATA);

endmodule : bxp_ports

`default_nettype wire

/* inc/bxp_pkg.sv */
package bxp_pkg;

    // ------------------------------------------------------------
    // target addresses on the management buses
    // ------------------------------------------------------------
    localparam logic [6:0] OUT_EXP_ADDR    = 7'h38;
    localparam logic [6:0] IN_EXP_ADDR     = 7'h39;
    localparam logic [6:0] CFG_EEPROM_ADDR = 7'h50;
    localparam logic [6:0] SPD_EEPROM_ADDR = 7'h51;
    localparam logic [6:0] RTC_ADDR        = 7'h68;

    // ------------------------------------------------------------
    // output expander fields
    // ------------------------------------------------------------
    localparam int GREEN_BIT   = 0;
    localparam int YELLOW_BIT  = 1;
    localparam int PHY_PD_BIT  = 2;
    localparam int DISP_EN_BIT = 4;
    localparam logic [7:0] OUT_PORT_RST = 8'hFF;
    localparam logic [7:0] OUT_READBACK = 8'hFF;

    // ------------------------------------------------------------
    // input expander fields
    // ------------------------------------------------------------
    localparam int REV_LO_BIT  = 0;
    localparam int REV_HI_BIT  = 1;
    localparam int CLKRUN_BIT  = 4;
    localparam int M66_BIT     = 5;
    localparam int BOOT_BIT    = 6;
    localparam logic [7:0] IN_IDLE     = 8'hFF;
    localparam logic       CLKRUN_RST  = 1'b1;

    // ------------------------------------------------------------
    // byte framing
    // ------------------------------------------------------------
    localparam logic [3:0] BIT_COUNT = 4'h8;
    localparam logic [3:0] BIT_LAST  = 4'h7;
    localparam logic [3:0] CNT_RST   = 4'h0;
    localparam logic [7:0] BYTE_RST  = 8'h00;

    // ------------------------------------------------------------
    // transfer states
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE     = 7'b000_0001,
        ST_ADDR     = 7'b000_0010,
        ST_ADDR_ACK = 7'b000_0100,
        ST_WR_DATA  = 7'b000_1000,
        ST_WR_ACK   = 7'b001_0000,
        ST_RD_DATA  = 7'b010_0000,
        ST_RD_ACK   = 7'b100_0000
    } bxp_state_t;

endpackage : bxp_pkg

/* src/bxp_line_cond.sv */
`timescale 1ns/100ps
`default_nettype none

module bxp_line_cond
    import bxp_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // bus pins
    input  wire logic scl_pin,
    input  wire logic sda_pin,
    // conditioned line state and events
    output logic      scl_s,
    output logic      sda_s,
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start_det,
    output logic      stop_det
);

    logic [1:0] meta_reg;
    logic [1:0] meta_next;
    logic [1:0] sync_reg;
    logic [1:0] sync_next;
    logic [1:0] dly_reg;
    logic [1:0] dly_next;

    // ------------------------------------------------------------
    // two-flop synchroniser plus one delay stage for edges
    // ------------------------------------------------------------
    always_comb begin
        meta_next = {scl_pin, sda_pin};
        sync_next = meta_reg;
        dly_next  = sync_reg;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= 2'b11;
            sync_reg <= 2'b11;
            dly_reg  <= 2'b11;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            dly_reg  <= dly_next;
        end
    end

    assign scl_s     = sync_reg[1];
    assign sda_s     = sync_reg[0];
    assign scl_rise  = sync_reg[1] & ~dly_reg[1];
    assign scl_fall  = ~sync_reg[1] & dly_reg[1];
    assign start_det = sync_reg[1] & dly_reg[1] & dly_reg[0] & ~sync_reg[0];
    assign stop_det  = sync_reg[1] & dly_reg[1] & ~dly_reg[0] & sync_reg[0];

endmodule : bxp_line_cond

`default_nettype wire

/* sim/bxp_i2c_master.sv */
`timescale 1ns/100ps
`default_nettype none

module bxp_i2c_master (
    // clock
    input  wire logic clock,
    // bus lines, data is open drain
    input  wire logic sda_line,
    output var logic  scl_drv,
    output var logic  sda_drv
);
    // ------------------------------------------------------------
    // idle bus
    // ------------------------------------------------------------
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end

    // ------------------------------------------------------------
    // bus phases, data moves only while clock is low, except in start and stop
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    task automatic start_cond;
        sda_drv <= 1'b1;
        tick(4);
        scl_drv <= 1'b1;
        tick(8);
        sda_drv <= 1'b0;
        tick(8);
        scl_drv <= 1'b0;
        tick(4);
    endtask : start_cond

    task automatic stop_cond;
        sda_drv <= 1'b0;
        tick(4);
        scl_drv <= 1'b1;
        tick(8);
        sda_drv <= 1'b1;
        tick(8);
    endtask : stop_cond

    task automatic bit_io(input logic b, output logic r);
        sda_drv <= b;
        tick(4);
        scl_drv <= 1'b1;
        tick(4);
        r = sda_line;
        tick(4);
        scl_drv <= 1'b0;
        tick(4);
    endtask : bit_io

    // msb first, ninth bit released for the target's ack
    task automatic byte_wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask : byte_wr

    task automatic byte_rd(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, r);
    endtask : byte_rd
endmodule : bxp_i2c_master

`default_nettype wire

/* sim/tb_board_i2c_expander_ports.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_board_i2c_expander_ports
    import bxp_pkg::*;
;
    logic       clock = 1'b0;
    logic       sys_rst = 1'b1;
    logic       scl, sda_m, sda_out, sda_oe_n;
    logic       green, yellow, phy, disp;
    logic       rev_hi = 1'b1, rev_lo = 1'b1, clkrun = 1'b1;
    logic       m66 = 1'b1, boot = 1'b1, latch = 1'b1;
    logic [7:0] d, d0, d1, last_out;
    logic [6:0] a;
    wire        sda_line = sda_m & (sda_oe_n | sda_out);
    int         seed = 34;
    int         miscompares = 0;
    int         cmp_count = 0;

    always #12.5 clock = ~clock;

    bxp_i2c_master mst (.clock(clock), .sda_line(sda_line),
                        .scl_drv(scl), .sda_drv(sda_m));

    bxp_ports DUT (
        .clock(clock), .sys_rst(sys_rst),
        .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .green_indicator_ctl(green), .yellow_indicator_ctl(yellow),
        .phy_power_down_ctl(phy), .display_enable_reserved(disp),
        .board_revision_hi(rev_hi), .board_revision_lo(rev_lo),
        .mini_slot_clock_run(clkrun), .slot_66mhz_capable(m66),
        .boot_second_bank(boot));

    // ------------------------------------------------------------
    // checking and expectations
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [7:0] exp_in(input logic l);
        return {1'b1, boot, m66, clkrun & l, 2'b11, rev_hi, rev_lo};
    endfunction : exp_in

    function automatic logic [7:0] pins();
        return {4'h0, disp, phy, yellow, green};
    endfunction : pins

    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------
    // transfers; up to n bytes written while acked, the last one is dv
    // ------------------------------------------------------------
    task automatic wr(input logic [6:0] ad, input logic [7:0] dv,
                      input logic ack_exp, input int n, input logic keep);
        logic ack;
        mst.start_cond();
        mst.byte_wr({ad, 1'b0}, ack);
        check("write addr ack", {7'h00, ack}, {7'h00, ack_exp});
        for (int k = n; k > 0 && ack; k--) begin
            mst.byte_wr((k == 1) ? dv : ~dv, ack);
            check("data ack", {7'h00, ack}, 8'h01);
        end
        if (!keep) begin
            mst.stop_cond();
        end
    endtask : wr

    task automatic rd(input logic [6:0] ad);
        logic ack;
        mst.start_cond();
        mst.byte_wr({ad, 1'b1}, ack);
        check("read addr ack", {7'h00, ack}, 8'h01);
        mst.byte_rd(1'b0, d0);
        mst.byte_rd(1'b1, d1);
        mst.stop_cond();
    endtask : rd

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        mst.tick(6);
        check("reset pins", pins(), 8'h0f);
        check("reset oe_n", {7'h00, sda_oe_n}, 8'h01);
        for (int i = 0; i < 5; i++) begin
            a = (i == 0) ? CFG_EEPROM_ADDR : (i == 1) ? SPD_EEPROM_ADDR :
                (i == 2) ? RTC_ADDR : 7'($random(seed));
            if (a[6:1] == 6'h1c) begin
                a = a ^ 7'h40;
            end
            wr(a, 8'h00, 1'b0, 1, 1'b0);
            check("foreign pins", pins(), 8'h0f);
        end
        for (int i = 0; i < 10; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            wr(OUT_EXP_ADDR, d, 1'b1, 1 + i % 2, i == 3);
            if (i == 3) begin
                rd(IN_EXP_ADDR);
                check("rs read", d0, exp_in(latch));
            end
            mst.tick(4);
            check("out pins", pins(), {4'h0, d[4], d[2:0]});
            last_out = d;
            rd(OUT_EXP_ADDR);
            check("out readback", d0, 8'hff);
            check("out readback 2", d1, 8'hff);
        end
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 8'h00 : 8'($random(seed));
            wr(IN_EXP_ADDR, d, 1'b1, 1, 1'b0);
            latch = d[4];
            @(posedge clock);
            {rev_hi, rev_lo} <= i[1:0];
            {clkrun, m66, boot} <= 3'($random(seed));
            mst.tick(4);
            rd(IN_EXP_ADDR);
            check("status byte", d0, exp_in(latch));
            check("status byte 2", d1, exp_in(latch));
            check("pins kept", pins(),
                  {4'h0, last_out[4], last_out[2:0]});
        end
        end_sim();
    end

    initial begin
        repeat (80000) @(posedge clock);
        miscompares++;
        end_sim();
    end
endmodule : tb_board_i2c_expander_ports

`default_nettype wire
